// file: hw/tss_core.sv
// Time slot switch core: two serial ports, data and connection memories, processor port
`default_nettype none
module tss_core
	import tss_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic master_clock_in,
	input wire logic master_frame_pulse_in,
	input wire logic [31:0] bp_rx_i,
	input wire logic [31:0] lc_rx_i,
	output logic [31:0] bp_tx_o,
	output logic [31:0] bp_oe_n_o,
	output logic [31:0] lc_tx_o,
	output logic [31:0] lc_oe_n_o,
	output logic clock_out_8m,
	output logic clock_out_16m,
	output logic frame_pulse_out_8m,
	output logic frame_pulse_out_16m,
	input wire logic [14:0] addr_i,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic data_oe_n_o,
	input wire logic cs_n_i,
	input wire logic ds_n_i,
	input wire logic rw_i,
	output logic dtack_n_o
);
	// ****************************************
	// State
	// ****************************************
	tss_run_type run_ff;
	tss_seq_type seq_ff;
	logic mck_q_ff, fp_q_ff, gci_ff, rate16_ff;
	logic [10:0] bcnt_ff;
	logic [1:0] bank_ff;
	logic [11:0] det_cnt_ff, hi_cnt_ff, seq_addr_ff;
	logic [1:0] fill_ff;
	logic bist_done_ff, bist_fail_ff;
	logic [2:0] dly_ff [2][STREAMS];
	logic [1:0] adv_ff [2][STREAMS];
	logic [7:0] sh_ff [2][STREAMS];
	logic [7:0] dm_ff [2][STREAMS][BANKS][CH_PER_SLICE];
	logic [15:0] cm_ff [2][4096];
	logic [31:0] tx_ff [2];
	logic [31:0] oe_n_ff [2];
	logic ck8_ff, ck16_ff, fpo_ff;
	logic [30:0] fq_ff [2];
	logic fq_wp_ff, fq_rp_ff;
	logic [1:0] fq_cnt_ff;
	logic acc_done_ff;
	logic [15:0] rdata_ff;
	logic oe_ff, dtack_ff;

	// Location of a channel byte; the stream field narrows at 16 Mbps
	function automatic logic [11:0] loc(input logic r16, input logic [4:0] s,
		input logic [10:0] q);
		return r16 ? {s[3:0], q[10:3]} : {s, q[9:3]};
	endfunction

	// ****************************************
	// Bit timing and frame alignment
	// ****************************************
	// one clock and one pulse time both ports
	wire mck_fall = mck_q_ff & ~master_clock_in;
	wire mck_edge = mck_q_ff ^ master_clock_in;
	wire tick = rate16_ff ? mck_edge : mck_fall;
	wire run = (run_ff == ST_RUN);
	wire fp_act = gci_ff ? master_frame_pulse_in : ~master_frame_pulse_in;
	wire fp_start = tick & run & fp_act & ~fp_q_ff;
	wire [11:0] flen = rate16_ff ? FRAME_BITS_16M : FRAME_BITS_8M;
	wire [10:0] blast = 11'(flen - 12'h0_001);
	wire [10:0] pos_now = fp_start ? 11'h0_00 : (bcnt_ff == blast ? bcnt_ff : bcnt_ff + 11'h0_01);
	wire [1:0] bank_prv = (bank_ff == 2'h0) ? 2'h2 : bank_ff - 2'h1;
	wire [1:0] bank_rd = (bank_ff == 2'h2) ? 2'h0 : bank_ff + 2'h1;

	// Frame counter saturates if pulses stop, so stale frames never alias
	always_ff @(posedge mclk_i) begin
		mck_q_ff <= rst_i ? 1'b0 : master_clock_in;
		if (rst_i) begin
			bcnt_ff <= 11'h0_00;
			fp_q_ff <= 1'b0;
		end else if (tick) begin
			bcnt_ff <= pos_now;
			fp_q_ff <= fp_act;
		end
	end

	// three banks rotate per frame; read bank is two frames old
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			bank_ff <= 2'h0;
		else if (fp_start)
			bank_ff <= bank_rd;
	end

	// ****************************************
	// Startup format detection
	// ****************************************
	// idle level over the window shows the pulse style
	// two frames of ticks before switching starts
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			run_ff <= ST_DETECT;
			det_cnt_ff <= 12'h0_000;
			hi_cnt_ff <= 12'h0_000;
			gci_ff <= 1'b0;
		end else if (!run && tick) begin
			det_cnt_ff <= det_cnt_ff + 12'h0_001;
			hi_cnt_ff <= hi_cnt_ff + {11'h0_00, master_frame_pulse_in};
			if (det_cnt_ff == DETECT_TICKS - 12'h0_001) begin
				run_ff <= ST_RUN;
				gci_ff <= (hi_cnt_ff < (DETECT_TICKS >> 1));
			end
		end
	end

	// ****************************************
	// Input side: delay, assemble, store
	// ****************************************
	logic in_we [2][STREAMS];
	logic [11:0] in_loc [2][STREAMS];
	logic [1:0] in_bank [2][STREAMS];
	logic [7:0] in_byte [2][STREAMS];

	for (genvar p = 0; p < 2; p++) begin : g_port
		wire [31:0] rx = (p == 0) ? bp_rx_i : lc_rx_i;
		for (genvar s = 0; s < STREAMS; s++) begin : g_str
			// delayed bit position; wrap belongs to previous frame
			wire late = {8'h0_0, dly_ff[p][s]} > pos_now;
			wire [11:0] dsum = {1'b0, pos_now} + (late ? flen : 12'h0_000)
				- {9'h0_00, dly_ff[p][s]};
			wire [10:0] dpos = dsum[10:0];
			// upper streams idle at 16 Mbps
			wire live = !rate16_ff || (s < STREAMS / 2);
			assign in_we[p][s] = tick & run & live & (dpos[2:0] == 3'h7);
			assign in_loc[p][s] = loc(rate16_ff, 5'(s), dpos);
			assign in_bank[p][s] = late ? bank_prv : bank_ff;
			assign in_byte[p][s] = {sh_ff[p][s][6:0], rx[s]};
			always_ff @(posedge mclk_i) begin
				if (rst_i)
					sh_ff[p][s] <= 8'h0_0;
				else if (tick)
					sh_ff[p][s] <= in_byte[p][s];
			end
			// slice s holds 128 locations of this port's data memory
			// byte written in its own frame's bank
			wire [4:0] src = rate16_ff ? 5'(s >> 1) : 5'(s);
			wire sl_we = in_we[p][src] & (in_loc[p][src][11:7] == 5'(s));
			always_ff @(posedge mclk_i) begin
				if (sl_we)
					dm_ff[p][s][in_bank[p][src]][in_loc[p][src][6:0]] <= in_byte[p][src];
			end
			// ****************************************
			// Output side: advance, select, drive
			// ****************************************
			// advanced position may reach into the next frame
			wire [11:0] osum = {1'b0, pos_now} + {10'h0_00, adv_ff[p][s]};
			wire ahead = osum >= flen;
			wire [10:0] opos = ahead ? 11'(osum - flen) : osum[10:0];
			wire [1:0] obank = ahead ? bank_prv : bank_rd;
			// each port has its own connection memory
			wire [15:0] ent = cm_ff[p][loc(rate16_ff, 5'(s), opos)];
			wire [11:0] sa = ent[11:0];
			// source port and location from the entry
			wire [7:0] sw_byte = dm_ff[ent[CM_SRC_PORT_BIT]][sa[11:7]][obank][sa[6:0]];
			wire [7:0] ob = ent[CM_MSG_BIT] ? ent[7:0] : sw_byte;
			wire [1:0] octl = ent[CM_CTRL_LSB +: 2];
			wire obit = (octl == OUT_HIGH) ? 1'b1 : ob[3'h7 - opos[2:0]];
			always_ff @(posedge mclk_i) begin
				if (rst_i || !run || !live) begin
					oe_n_ff[p][s] <= 1'b1;
					tx_ff[p][s] <= 1'b0;
				end else if (tick) begin
					oe_n_ff[p][s] <= (octl == OUT_HIZ);
					tx_ff[p][s] <= obit;
				end
			end
		end
	end
	assign bp_tx_o = tx_ff[0];
	assign bp_oe_n_o = oe_n_ff[0];
	assign lc_tx_o = tx_ff[1];
	assign lc_oe_n_o = oe_n_ff[1];

	// ****************************************
	// Clock and frame pulse outputs
	// ****************************************
	// clock_out_8m follows master clock, clock_out_16m toggles on each of its edges; frame pulse in the detected polarity
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ck8_ff <= 1'b0;
			ck16_ff <= 1'b0;
			fpo_ff <= 1'b1;
		end else begin
			ck8_ff <= master_clock_in;
			ck16_ff <= mck_edge ? ~ck16_ff : ck16_ff;
			if (tick)
				fpo_ff <= (pos_now == 11'h0_00) ? gci_ff : ~gci_ff;
		end
	end
	assign clock_out_8m = ck8_ff;
	assign clock_out_16m = ck16_ff;
	assign frame_pulse_out_8m = fpo_ff;
	assign frame_pulse_out_16m = fpo_ff;

	// ****************************************
	// Processor port and write buffer
	// ****************************************
	// access taken while select and strobe are low
	wire req = ~cs_n_i & ~ds_n_i & ~acc_done_ff;
	wire fq_in_ready = (fq_cnt_ff != 2'h2);
	wire fq_out_valid = (fq_cnt_ff != 2'h0);
	wire seq_idle = (seq_ff == SQ_IDLE);
	wire fq_out_ready = seq_idle;
	// writes before startup are acknowledged but dropped
	wire push = req & ~rw_i & run & fq_in_ready;
	wire wr_drop = req & ~rw_i & ~run;
	// Reads wait for queued writes so they never return old contents
	wire rd_take = req & rw_i & ~fq_out_valid;
	wire pop = fq_out_valid & fq_out_ready;
	wire [30:0] head = fq_ff[fq_rp_ff];
	wire [14:0] h_addr = head[30:16];
	wire [15:0] h_data = head[15:0];
	wire h_reg = ~h_addr[ADDR_MEM_BIT];
	wire h_cm = h_addr[ADDR_MEM_BIT] & h_addr[ADDR_CM_BIT];
	wire [1:0] h_page = h_addr[7:6];

	// Full buffer holds back the acknowledge, stalling the processor
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fq_wp_ff <= 1'b0;
			fq_rp_ff <= 1'b0;
			fq_cnt_ff <= 2'h0;
		end else begin
			if (push) begin
				fq_ff[fq_wp_ff] <= {addr_i, data_i};
				fq_wp_ff <= ~fq_wp_ff;
			end
			fq_rp_ff <= pop ? ~fq_rp_ff : fq_rp_ff;
			fq_cnt_ff <= fq_cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	// read decode: registers, connection and data memories
	wire [1:0] rd_page = addr_i[7:6];
	wire [15:0] rd_reg =
		(addr_i[7:0] == OFF_CTRL) ? {15'h0_000, rate16_ff} :
		(addr_i[7:0] == OFF_BLOCK) ? {13'h0_000, fill_ff, seq_ff == SQ_BLOCK} :
		(addr_i[7:0] == OFF_BIST) ? {13'h0_000, bist_fail_ff, bist_done_ff, ~seq_idle} :
		(rd_page == OFF_DELAY_PAGE) ? {13'h0_000, dly_ff[addr_i[5]][addr_i[4:0]]} :
		(rd_page == OFF_ADV_PAGE) ? {14'h0_000, adv_ff[addr_i[5]][addr_i[4:0]]} : 16'h0_000;
	wire [11:0] ra = addr_i[11:0];
	wire [15:0] rd_mem = addr_i[ADDR_CM_BIT] ? cm_ff[addr_i[ADDR_PORT_BIT]][ra] :
		{8'h0_0, dm_ff[addr_i[ADDR_PORT_BIT]][ra[11:7]][bank_prv][ra[6:0]]};
	wire [15:0] rd_val = addr_i[ADDR_MEM_BIT] ? rd_mem : rd_reg;

	// acknowledge held until the strobe is released
	always_ff @(posedge mclk_i) begin
		if (rst_i || ds_n_i || cs_n_i) begin
			acc_done_ff <= 1'b0;
			dtack_ff <= 1'b1;
			oe_ff <= 1'b1;
			rdata_ff <= 16'h0_000;
		end else if (push || wr_drop || rd_take) begin
			acc_done_ff <= 1'b1;
			dtack_ff <= 1'b0;
			oe_ff <= ~rd_take;
			rdata_ff <= rd_take ? rd_val : rdata_ff;
		end
	end
	assign data_o = rdata_ff;
	assign data_oe_n_o = oe_ff;
	assign dtack_n_o = dtack_ff;

	// Register writes drained from the buffer
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rate16_ff <= CTRL_RESET;
			for (int p = 0; p < 2; p++) begin
				for (int s = 0; s < STREAMS; s++) begin
					dly_ff[p][s] <= 3'h0;
					adv_ff[p][s] <= 2'h0;
				end
			end
		end else if (pop && h_reg) begin
			if (h_addr[7:0] == OFF_CTRL)
				rate16_ff <= h_data[0];
			if (h_page == OFF_DELAY_PAGE)
				dly_ff[h_addr[5]][h_addr[4:0]] <= h_data[2:0];
			if (h_page == OFF_ADV_PAGE)
				adv_ff[h_addr[5]][h_addr[4:0]] <= h_data[1:0];
		end
	end

	// ****************************************
	// Block fill and self test sequencer
	// ****************************************
	wire blk_go = pop & h_reg & (h_addr[7:0] == OFF_BLOCK) & h_data[0];
	wire bist_go = pop & h_reg & (h_addr[7:0] == OFF_BIST) & h_data[0];
	wire seq_end = (seq_addr_ff == LOC_LAST);
	wire [15:0] pat = {~seq_addr_ff[3:0], seq_addr_ff};
	wire cm_seq_we = (seq_ff == SQ_BLOCK) || (seq_ff == SQ_BIST_WR);
	wire [15:0] cm_seq_d = (seq_ff == SQ_BLOCK) ? {fill_ff, 14'h0_000} : pat;
	wire bist_miss = (seq_ff == SQ_BIST_RD) &&
		((cm_ff[0][seq_addr_ff] != pat) || (cm_ff[1][seq_addr_ff] != pat));

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			seq_ff <= SQ_IDLE;
			seq_addr_ff <= 12'h0_000;
			fill_ff <= 2'h0;
			bist_done_ff <= 1'b0;
			bist_fail_ff <= 1'b0;
		end else begin
			seq_addr_ff <= (seq_idle || seq_end) ? 12'h0_000 : seq_addr_ff + 12'h0_001;
			unique case (seq_ff)
				SQ_IDLE: begin
					// bulk fill with the chosen output control
					if (blk_go) begin
						seq_ff <= SQ_BLOCK;
						fill_ff <= h_data[2:1];
					end
					if (bist_go) begin
						seq_ff <= SQ_BIST_WR;
						bist_done_ff <= 1'b0;
						bist_fail_ff <= 1'b0;
					end
				end
				SQ_BLOCK:
					seq_ff <= seq_end ? SQ_IDLE : SQ_BLOCK;
				SQ_BIST_WR:
					seq_ff <= seq_end ? SQ_BIST_RD : SQ_BIST_WR;
				SQ_BIST_RD: begin
					bist_fail_ff <= bist_fail_ff | bist_miss;
					if (seq_end) begin
						seq_ff <= SQ_IDLE;
						bist_done_ff <= 1'b1;
					end
				end
			endcase
		end
	end

	// connection memory write port shared by processor and sequencer
	for (genvar p = 0; p < 2; p++) begin : g_cm
		wire cpu_we = pop & h_cm & (h_addr[ADDR_PORT_BIT] == 1'(p));
		wire [11:0] wa = cm_seq_we ? seq_addr_ff : h_addr[11:0];
		always_ff @(posedge mclk_i) begin
			if (cm_seq_we || cpu_we)
				cm_ff[p][wa] <= cm_seq_we ? cm_seq_d : h_data;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	wire [15:0] e0 = cm_ff[0][loc(rate16_ff, 5'h0_0, pos_now)];
	a_hiz_before_run: assert property (!run |=> (bp_oe_n_o == '1) && (lc_oe_n_o == '1))
		else $error("output driven before startup");
	a_detect_two_frames: assert property ($rose(run) |-> $past(det_cnt_ff) == DETECT_TICKS - 12'h0_001)
		else $error("switching began before two frames");
	a_no_early_write: assert property (!run |=> $stable(rate16_ff) && fq_cnt_ff == 2'h0)
		else $error("write taken before startup");
	a_dtack_release: assert property (ds_n_i |=> dtack_n_o && data_oe_n_o)
		else $error("acknowledge held after strobe release");
	a_chan_hiz: assert property (tick && run && adv_ff[0][0] == 2'h0 && e0[15:14] == OUT_HIZ |=> bp_oe_n_o[0])
		else $error("channel not released");
	a_chan_high: assert property (tick && run && adv_ff[0][0] == 2'h0 && e0[15:14] == OUT_HIGH |=> bp_tx_o[0] && !bp_oe_n_o[0])
		else $error("channel not forced high");
	a_msg_bit: assert property (tick && run && adv_ff[0][0] == 2'h0 && e0[15:13] == 3'h1 |=> bp_tx_o[0] == $past(e0[3'h7 - pos_now[2:0]]))
		else $error("message bit wrong");
	a_bank_rotate: assert property (fp_start |=> bank_ff == $past(bank_rd) && bank_ff != 2'h3)
		else $error("bank did not rotate");
	a_block_end: assert property (seq_ff == SQ_BLOCK && seq_end |=> seq_idle && cm_ff[1][LOC_LAST][15:14] == fill_ff)
		else $error("block fill did not finish");
	a_bist_report: assert property (seq_ff == SQ_BIST_RD && seq_end |=> bist_done_ff ##1 seq_idle)
		else $error("self test not reported");
	c_run_reached: cover property ($rose(run));
	c_block_done: cover property (seq_ff == SQ_BLOCK && seq_end);
	c_bist_pass: cover property ($rose(bist_done_ff) && !bist_fail_ff);
	c_buffer_full: cover property (fq_cnt_ff == 2'h2);
endmodule
`default_nettype wire

// file: hw/tss_pkg.sv
// Constants and types shared by the time slot switch core
`default_nettype none
package tss_pkg;
	// ****************************************
	// Stream geometry
	// ****************************************
	localparam int STREAMS = 32;
	localparam int CH_PER_SLICE = 128;
	localparam int BANKS = 3;
	localparam logic [11:0] FRAME_BITS_8M = 12'h0_400;
	localparam logic [11:0] FRAME_BITS_16M = 12'h0_800;
	localparam int STARTUP_FRAMES = 2;
	localparam logic [11:0] DETECT_TICKS = 12'h0_800;
	localparam logic [11:0] LOC_LAST = 12'h0_FFF;
	// ****************************************
	// Processor map
	// ****************************************
	localparam int ADDR_MEM_BIT = 14;
	localparam int ADDR_CM_BIT = 13;
	localparam int ADDR_PORT_BIT = 12;
	localparam logic [7:0] OFF_CTRL = 8'h0_0;
	localparam logic [7:0] OFF_BLOCK = 8'h0_1;
	localparam logic [7:0] OFF_BIST = 8'h0_2;
	localparam logic [1:0] OFF_DELAY_PAGE = 2'h1;
	localparam logic [1:0] OFF_ADV_PAGE = 2'h2;
	localparam logic CTRL_RESET = 1'h0;
	// ****************************************
	// Connection memory entry fields
	// ****************************************
	localparam int CM_SRC_PORT_BIT = 12;
	localparam int CM_MSG_BIT = 13;
	localparam int CM_CTRL_LSB = 14;
	localparam logic [1:0] OUT_NORMAL = 2'h0;
	localparam logic [1:0] OUT_HIZ = 2'h1;
	localparam logic [1:0] OUT_HIGH = 2'h2;
	typedef enum logic [0:0] {
		ST_DETECT = 1'b0,
		ST_RUN = 1'b1
	} tss_run_type;
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_BLOCK = 2'b01,
		SQ_BIST_WR = 2'b10,
		SQ_BIST_RD = 2'b11
	} tss_seq_type;
endpackage
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the time slot switch core
`default_nettype none
module testbench
	import tss_pkg::*, tss_tb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic mck, mfp, ck8, ck16, fp8, fp16, doe_n, dtack_n;
	logic [31:0] bp_rx, lc_rx, bp_tx, bp_oe_n, lc_tx, lc_oe_n;
	logic [14:0] addr = '0;
	logic [15:0] wdata = '0;
	logic [15:0] rdata, rdq;
	logic cs_n = 1'b1;
	logic ds_n = 1'b1;
	logic rw = 1'b1;
	logic ck_prev = 1'b0;
	logic ck8_prev = 1'b0;
	logic ck16_prev = 1'b0;
	logic fp_prev = 1'b1;
	logic run = 1'b0;
	logic op [24];
	logic [11:0] ol [24];
	logic [15:0] ent [24];
	logic [15:0] kind [4] = '{16'h0000, 16'h2000, 16'h4000, 16'h8000};
	int n_fail = 0;
	int cmp_count = 0;
	int fp_falls = 0;
	int fr, f0, n0;
	logic [9:0] pos;
	tss_core tss_core_inst (.mclk_i(mclk_i), .rst_i(rst_i), .master_clock_in(mck),
		.master_frame_pulse_in(mfp), .bp_rx_i(bp_rx), .lc_rx_i(lc_rx), .bp_tx_o(bp_tx),
		.bp_oe_n_o(bp_oe_n), .lc_tx_o(lc_tx), .lc_oe_n_o(lc_oe_n), .clock_out_8m(ck8),
		.clock_out_16m(ck16), .frame_pulse_out_8m(fp8), .frame_pulse_out_16m(fp16),
		.addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_n_o(doe_n), .cs_n_i(cs_n),
		.ds_n_i(ds_n), .rw_i(rw), .dtack_n_o(dtack_n));
	tss_framer_model tss_framer_model_inst (.mclk_i(mclk_i), .master_clock_in(mck),
		.master_frame_pulse_in(mfp), .bp_rx_o(bp_rx), .lc_rx_o(lc_rx), .bp_tx_i(bp_tx),
		.bp_oe_n_i(bp_oe_n), .lc_tx_i(lc_tx), .lc_oe_n_i(lc_oe_n), .fr_o(fr), .pos_o(pos));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one strobe per access, held until acknowledge
	task automatic bus(input logic r, input logic [14:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		cs_n <= 1'b0;
		ds_n <= 1'b0;
		rw <= r;
		addr <= a;
		wdata <= d;
		do begin @(posedge mclk_i); n++; end while (dtack_n !== 1'b0 && n < 20000);
		rdq = rdata;
		check(doe_n === !r, "read data enable wrong");
		cs_n <= 1'b1;
		ds_n <= 1'b1;
		do begin @(posedge mclk_i); n++; end while (dtack_n !== 1'b1 && n < 20000);
		check(n < 20000, "bus handshake timed out");
	endtask
	task automatic poll(input logic [7:0] off);
		int k;
		k = 0;
		do begin bus(1'b1, 15'(off), 16'h0000); k++; end while (rdq[0] !== 1'b0 && k < 9000);
		check(k < 9000, "sequencer stayed busy");
	endtask
	task automatic at_pos(input int f, input logic [9:0] p);
		while (!(fr == f && pos == p)) @(posedge mclk_i);
	endtask
	function automatic logic [8:0] expect_cap(input logic [15:0] e, input int f);
		if (e[15:14] == OUT_HIGH)
			return 9'h0FF;
		if (e[13])
			return {1'b0, e[7:0]};
		return {1'b0, byte_of(f - 2, e[12], e[11:7], e[6:0])};
	endfunction
	// Output clock follows master clock; count output frame pulses
	always @(posedge mclk_i) begin
		ck_prev <= mck;
		fp_prev <= fp8;
		ck8_prev <= ck8;
		ck16_prev <= ck16;
		if (fp_prev === 1'b1 && fp8 === 1'b0)
			fp_falls <= fp_falls + 1;
		if (run) begin
			check(ck8 === ck_prev, "clock_out_8m lost the master clock");
			check((ck16 !== ck16_prev) === (ck8 !== ck8_prev), "clock_out_16m missed an edge");
			check(fp16 === fp8, "frame_pulse_out_16m differs");
		end
	end
	initial begin
		repeat (95000) @(posedge mclk_i);
		n_fail++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		final_report();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h4732));
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		bus(1'b0, 15'(OFF_CTRL), 16'h0001);
		check((&{bp_oe_n, lc_oe_n}) === 1'b1, "outputs driven in startup");
		at_pos(fr + 3, 10'h000);
		bus(1'b1, 15'(OFF_CTRL), 16'h0000);
		check(rdq === 16'h0000, "startup write was kept");
		bus(1'b1, 15'h0003, 16'h0000);
		check(rdq === 16'h0000, "unmapped register not zero");
		bus(1'b0, 15'(OFF_BIST), 16'h0001);
		poll(OFF_BIST);
		check(rdq[2:1] === 2'b01, "self test not clean");
		// Bulk fill to high impedance, then back to normal switching
		bus(1'b0, 15'(OFF_BLOCK), {13'h0000, OUT_HIZ, 1'b1});
		poll(OFF_BLOCK);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, {2'b11, 13'($urandom)}, 16'h0000);
			check(rdq === {OUT_HIZ, 14'h0000}, "block fill entry wrong");
		end
		bus(1'b0, 15'(OFF_BLOCK), {13'h0000, OUT_NORMAL, 1'b1});
		poll(OFF_BLOCK);
		// Random connections of all four kinds on distinct output channels
		for (int i = 0; i < 24; i++) begin
			op[i] = 1'($urandom);
			ol[i] = {5'($urandom), 7'(i * 5 + 3)};
			ent[i] = (16'($urandom) & 16'h1FFF) | kind[i % 4];
			bus(1'b0, {2'b11, op[i], ol[i]}, ent[i]);
		end
		bus(1'b1, {2'b11, op[1], ol[1]}, 16'h0000);
		check(rdq === ent[1], "connection entry readback");
		// Start counting clear of the frame pulse so the first fall is not split
		at_pos(fr + 1, 10'h010);
		f0 = fr;
		n0 = fp_falls;
		run <= 1'b1;
		// Two successive frames show the same two-frame delay
		for (int f = f0 + 2; f < f0 + 4; f++) begin
			at_pos(f + 1, 10'h004);
			for (int i = 0; i < 24; i++) begin
				if (ent[i][15:14] == OUT_HIZ)
					check(tss_framer_model_inst.cap[op[i]][ol[i][11:7]][ol[i][6:0]][8] === 1'b1,
						"channel not high impedance");
				else
					check(tss_framer_model_inst.cap[op[i]][ol[i][11:7]][ol[i][6:0]]
						=== expect_cap(ent[i], f), "switched byte wrong");
			end
		end
		check(fp_falls - n0 === fr - f0, "output frame pulse count");
		run <= 1'b0;
		// Data memory shows the last complete frame and ignores writes
		at_pos(fr + 1, 10'h100);
		for (int i = 0; i < 6; i++) begin
			ol[i] = 12'($urandom);
			op[i] = 1'($urandom);
			bus(1'b0, {2'b10, op[i], ol[i]}, 16'h00A5);
			bus(1'b1, {2'b10, op[i], ol[i]}, 16'h0000);
			check(rdq[7:0] === byte_of(fr - 1, op[i], ol[i][11:7], ol[i][6:0]),
				"data memory byte wrong");
		end
		final_report();
	end
endmodule
`default_nettype wire

// file: verif/tss_framer_model.sv
// Far side model: master timing, serial sources and capture of outputs
`default_nettype none
module tss_framer_model
	import tss_tb_pkg::*;
(
	input wire logic mclk_i,
	output logic master_clock_in = 1'b1,
	output logic master_frame_pulse_in = 1'b1,
	output logic [31:0] bp_rx_o = '0,
	output logic [31:0] lc_rx_o = '0,
	input wire logic [31:0] bp_tx_i,
	input wire logic [31:0] bp_oe_n_i,
	input wire logic [31:0] lc_tx_i,
	input wire logic [31:0] lc_oe_n_i,
	output int fr_o = 0,
	output logic [9:0] pos_o = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph_ff = 2'h0;
	logic [7:0] b;
	logic [7:0] sh_ff [2][32];
	logic [8:0] cap [2][32][128];
	logic [9:0] pp;
	logic t;
	assign pp = pos_o - 10'h001;
	// Master clock of four system cycles, data set mid-bit, sampled at fall
	always @(posedge mclk_i) begin
		ph_ff <= ph_ff + 2'h1;
		if (ph_ff == 2'h1) begin
			master_clock_in <= 1'b1;
			// style pulse low at first tick
			master_frame_pulse_in <= (pos_o != 10'h000);
			for (int s = 0; s < 32; s++) begin
				b = byte_of(fr_o, 0, s, pos_o[9:3]);
				bp_rx_o[s] <= b[~pos_o[2:0]];
				b = byte_of(fr_o, 1, s, pos_o[9:3]);
				lc_rx_o[s] <= b[~pos_o[2:0]];
			end
		end
		if (ph_ff == 2'h3) begin
			master_clock_in <= 1'b0;
			pos_o <= pos_o + 10'h001;
			if (pos_o == 10'h3FF)
				fr_o <= fr_o + 1;
			// Bit of the previous tick still stands here; byte kept with its enable
			for (int p = 0; p < 2; p++) begin
				for (int s = 0; s < 32; s++) begin
					t = p ? lc_tx_i[s] : bp_tx_i[s];
					sh_ff[p][s] <= {sh_ff[p][s][6:0], t};
					if (pp[2:0] == 3'h7)
						cap[p][s][pp[9:3]] <= {p ? lc_oe_n_i[s] : bp_oe_n_i[s], sh_ff[p][s][6:0], t};
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/tss_tb_pkg.sv
// Bench helper functions for the time slot switch core
`default_nettype none
package tss_tb_pkg;
	// Byte sent by the framer; the frame term makes stale data visible
	function automatic logic [7:0] byte_of(input int f, input int p, input int s, input int c);
		return 8'(f * 29 + p * 89 + s * 11 + c * 3);
	endfunction
endpackage
`default_nettype wire
